// ==== core/snfe_front_end.v ====
`timescale 1ns/1ps
`include "snfe_consts.vh"
module snfe_front_end (
  input  wire                   clk_i,
  input  wire                   reset_i,
  input  wire                   cs_n_i,
  input  wire                   sck_i,
  input  wire [3:0]             io_i,
  input  wire                   pause_en_i,
  input  wire                   lock_write_disable_i,
  input  wire                   prot_wr_i,
  input  wire [3:0]             prot_range_new_i,
  input  wire                   prot_tb_new_i,
  input  wire [7:0]             tx_data_i,
  output reg  [3:0]             io_o,
  output reg  [3:0]             io_oe_o,
  output reg                    selected_o,
  output reg                    paused_o,
  output reg  [7:0]             opcode_o,
  output reg                    opcode_valid_o,
  output reg  [`SNFE_COL_W-1:0] col_addr_o,
  output reg                    col_valid_o,
  output reg                    col_err_o,
  output reg  [7:0]             rx_data_o,
  output reg                    rx_valid_o,
  output reg                    tx_req_o,
  output reg  [3:0]             protect_range_bits_o,
  output reg                    protect_top_bottom_o,
  output reg                    prot_wr_reject_o
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_OPC   = 3'h1;
  localparam ST_ADDR  = 3'h2;
  localparam ST_DUMMY = 3'h3;
  localparam ST_DIN   = 3'h4;
  localparam ST_DOUT  = 3'h5;

  wire [`SNFE_SYNC_W-1:0] s_w;
  wire                    s_cs_n;
  wire                    s_sck;
  wire [3:0]              s_io;
  wire                    sel;
  wire                    sck_rise;
  wire                    sck_fall;
  wire                    hold;
  wire                    rise_v;
  wire                    fall_v;
  wire                    pause_en;
  wire [15:0]             sr_next;
  wire [7:0]              din_byte;
  wire [4:0]              din_cnt;
  wire [7:0]              out_src;

  reg [2:0]  state_q;
  reg [4:0]  cnt_q;
  reg [15:0] sr_q;
  reg [2:0]  lw_q;
  reg        is_rd_q;
  reg [7:0]  tx_sr_q;
  reg [2:0]  ocnt_q;
  reg        out_on_q;
  reg        sck_prev_q;
  reg [3:0]  lanes;
  reg [3:0]  oe_mask;
  reg [2:0]  ocnt_init;

  // sck and io pass the same two stages so data stays aligned to its edge
  // select goes in inverted so the reset value of the stages reads as deselected
  snfe_sync #(
    .W (`SNFE_SYNC_W)
  ) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     ({~cs_n_i, sck_i, io_i}),
    .q_o     (s_w)
  );

  assign s_cs_n   = ~s_w[5];
  assign s_sck    = s_w[4];
  assign s_io     = s_w[3:0];
  assign sel      = ~s_cs_n;
  // edges only count while selected, so idle level of mode 0 or 3 is harmless
  assign sck_rise = sel & s_sck & ~sck_prev_q;
  assign sck_fall = sel & ~s_sck & sck_prev_q;
  // line 3 is data in four-line phases, so pause cannot be used there
  assign pause_en = pause_en_i & sel &
                    ~(((state_q == ST_DIN) | (state_q == ST_DOUT)) &
                      (lw_q == `SNFE_LW_X4));

  snfe_pause u_pause (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .en_i       (pause_en),
    .pause_n_i  (s_io[3]),
    .sck_i      (s_sck),
    .sck_fall_i (sck_fall),
    .hold_o     (hold)
  );

  assign rise_v = sck_rise & ~hold;
  assign fall_v = sck_fall & ~hold;

  assign sr_next = {sr_q[14:0], s_io[0]};
  // wider lanes: highest line holds the most significant bit
  assign din_byte = (lw_q == `SNFE_LW_X4) ? {sr_q[3:0], s_io[3:0]} :
                    (lw_q == `SNFE_LW_X2) ? {sr_q[5:0], s_io[1:0]} :
                    sr_next[7:0];
  assign din_cnt  = cnt_q + {2'b00, lw_q};
  assign out_src  = (ocnt_q == 3'h0) ? tx_data_i : tx_sr_q;

  always @* begin
    case (lw_q)
      `SNFE_LW_X4: begin
        lanes     = out_src[7:4];
        oe_mask   = `SNFE_OE_X4;
        ocnt_init = `SNFE_OCNT_X4;
      end
      `SNFE_LW_X2: begin
        lanes     = {2'b00, out_src[7:6]};
        oe_mask   = `SNFE_OE_X2;
        ocnt_init = `SNFE_OCNT_X2;
      end
      default: begin
        lanes     = {2'b00, out_src[7], 1'b0};
        oe_mask   = `SNFE_OE_X1;
        ocnt_init = `SNFE_OCNT_X1;
      end
    endcase
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q        <= ST_IDLE;
      cnt_q          <= 5'h00;
      sr_q           <= 16'h0000;
      lw_q           <= `SNFE_LW_X1;
      is_rd_q        <= 1'b0;
      tx_sr_q        <= 8'h00;
      ocnt_q         <= 3'h0;
      out_on_q       <= 1'b0;
      sck_prev_q     <= 1'b0;
      io_o           <= 4'h0;
      io_oe_o        <= 4'h0;
      selected_o     <= 1'b0;
      paused_o       <= 1'b0;
      opcode_o       <= 8'h00;
      opcode_valid_o <= 1'b0;
      col_addr_o     <= {`SNFE_COL_W{1'b0}};
      col_valid_o    <= 1'b0;
      col_err_o      <= 1'b0;
      rx_data_o      <= 8'h00;
      rx_valid_o     <= 1'b0;
      tx_req_o       <= 1'b0;
    end else begin
      sck_prev_q     <= s_sck;
      selected_o     <= sel;
      paused_o       <= hold;
      opcode_valid_o <= 1'b0;
      rx_valid_o     <= 1'b0;
      tx_req_o       <= 1'b0;
      if (!sel) begin
        // deselected: every line is an input, output floats
        // a pause is dropped too, since its enable needs selection
        state_q  <= ST_IDLE;
        cnt_q    <= 5'h00;
        ocnt_q   <= 3'h0;
        out_on_q <= 1'b0;
        lw_q     <= `SNFE_LW_X1;
        io_oe_o  <= 4'h0;
      end else begin
        // outputs float during a pause, keep their lanes otherwise
        io_oe_o <= (out_on_q & ~hold & (state_q == ST_DOUT)) ? oe_mask : 4'h0;
        case (state_q)
          ST_IDLE: begin
            // a new command starts only from a select falling edge
            state_q <= ST_OPC;
            cnt_q   <= 5'h00;
          end
          ST_OPC: begin
            if (rise_v) begin
              sr_q  <= sr_next;
              cnt_q <= cnt_q + 5'h01;
              if (cnt_q == `SNFE_BYTE_LAST) begin
                cnt_q          <= 5'h00;
                opcode_o       <= sr_next[7:0];
                opcode_valid_o <= 1'b1;
                case (sr_next[7:0])
                  `SNFE_OP_RD_X1A, `SNFE_OP_RD_X1B: begin
                    state_q <= ST_ADDR;
                    is_rd_q <= 1'b1;
                    lw_q    <= `SNFE_LW_X1;
                  end
                  `SNFE_OP_RD_X2: begin
                    state_q <= ST_ADDR;
                    is_rd_q <= 1'b1;
                    lw_q    <= `SNFE_LW_X2;
                  end
                  `SNFE_OP_RD_X4: begin
                    state_q <= ST_ADDR;
                    is_rd_q <= 1'b1;
                    lw_q    <= `SNFE_LW_X4;
                  end
                  `SNFE_OP_LD_X1, `SNFE_OP_LDR_X1: begin
                    state_q <= ST_ADDR;
                    is_rd_q <= 1'b0;
                    lw_q    <= `SNFE_LW_X1;
                  end
                  `SNFE_OP_LD_X4, `SNFE_OP_LDR_X4: begin
                    state_q <= ST_ADDR;
                    is_rd_q <= 1'b0;
                    lw_q    <= `SNFE_LW_X4;
                  end
                  default: begin
                    // other commands: raw single-line bytes to the user side
                    state_q <= ST_DIN;
                    is_rd_q <= 1'b0;
                    lw_q    <= `SNFE_LW_X1;
                  end
                endcase
              end
            end
          end
          ST_ADDR: begin
            if (rise_v) begin
              sr_q  <= sr_next;
              cnt_q <= cnt_q + 5'h01;
              if (cnt_q == `SNFE_ADDR_LAST) begin
                cnt_q       <= 5'h00;
                // out of range columns are flagged only, the address still passes
                col_addr_o  <= sr_next[`SNFE_COL_W-1:0];
                col_valid_o <= (sr_next[`SNFE_COL_W-1:0] <= `SNFE_COL_LAST);
                col_err_o   <= (sr_next[`SNFE_COL_W-1:0] > `SNFE_COL_LAST);
                state_q     <= is_rd_q ? ST_DUMMY : ST_DIN;
              end
            end
          end
          ST_DUMMY: begin
            if (rise_v) begin
              cnt_q <= cnt_q + 5'h01;
              if (cnt_q == `SNFE_BYTE_LAST) begin
                cnt_q   <= 5'h00;
                state_q <= ST_DOUT;
              end
            end
          end
          ST_DIN: begin
            // host keeps selection until the last data bit is in
            if (rise_v) begin
              sr_q  <= {8'h00, din_byte};
              cnt_q <= din_cnt;
              if (din_cnt == `SNFE_BYTE_BITS) begin
                cnt_q      <= 5'h00;
                rx_data_o  <= din_byte;
                rx_valid_o <= 1'b1;
              end
            end
          end
          ST_DOUT: begin
            // host has released line 0 (and 2, 3 for four lanes) here
            if (fall_v) begin
              io_o     <= lanes;
              io_oe_o  <= oe_mask;
              out_on_q <= 1'b1;
              if (ocnt_q == 3'h0) begin
                // a byte start consumes tx_data_i, so the user side must have it ready
                tx_sr_q  <= tx_data_i << lw_q;
                ocnt_q   <= ocnt_init;
                tx_req_o <= 1'b1;
              end else begin
                tx_sr_q <= tx_sr_q << lw_q;
                ocnt_q  <= ocnt_q - 3'h1;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // protect bits frozen while write protect is low and lock is set
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      protect_range_bits_o <= `SNFE_PROT_RNG_RST;
      protect_top_bottom_o <= `SNFE_PROT_TB_RST;
      prot_wr_reject_o     <= 1'b0;
    end else begin
      // refusal and update never share a cycle
      prot_wr_reject_o <= 1'b0;
      if (prot_wr_i) begin
        if (~s_io[2] & lock_write_disable_i) begin
          prot_wr_reject_o <= 1'b1;
        end else begin
          protect_range_bits_o <= prot_range_new_i;
          protect_top_bottom_o <= prot_tb_new_i;
        end
      end
    end
  end
endmodule

// ==== core/snfe_consts.vh ====
// Overview of operation
// - command, address and input bits are sampled at each serial clock rising edge.
// - each new output bit is driven after a serial clock falling edge.
// - only clock modes 0 and 3; both sample on rise, drive on fall.
// - write protect low plus lock write disable rejects protect bit updates.
// - pause is off unless enabled; pause line relies on an external pull-up.
// - pause only starts while selected; it suspends traffic without deselecting.
// - while paused the output floats and clock and input activity are ignored.
// - pause starts at pause line fall if clock low, else next clock fall.
// - pause ends at pause line rise if clock low, else after next clock fall.
// - while deselected, lines 0, 2 and write protect are inputs; 1, 3 output-side.
// - column address is 12 bits; only bytes 0 to 2175 exist in a page.
// - single-line mode carries opcode, address and data on one line.
// - extended mode sends opcode and address on line 0, data on two or four lines.
// - select low activates the device; select high deselects and floats the output.
`ifndef SNFE_CONSTS_VH
`define SNFE_CONSTS_VH
`define SNFE_SYNC_W       6
`define SNFE_BYTE_LAST    5'h07
`define SNFE_ADDR_LAST    5'h0f
`define SNFE_BYTE_BITS    5'h08
`define SNFE_COL_W        12
`define SNFE_COL_LAST     12'h87f
`define SNFE_LW_X1        3'h1
`define SNFE_LW_X2        3'h2
`define SNFE_LW_X4        3'h4
`define SNFE_OCNT_X1      3'h7
`define SNFE_OCNT_X2      3'h3
`define SNFE_OCNT_X4      3'h1
`define SNFE_OE_X1        4'h2
`define SNFE_OE_X2        4'h3
`define SNFE_OE_X4        4'hf
`define SNFE_OP_RD_X1A    8'h03
`define SNFE_OP_RD_X1B    8'h0b
`define SNFE_OP_RD_X2     8'h3b
`define SNFE_OP_RD_X4     8'h6b
`define SNFE_OP_LD_X1     8'h02
`define SNFE_OP_LD_X4     8'h32
`define SNFE_OP_LDR_X1    8'h84
`define SNFE_OP_LDR_X4    8'h34
`define SNFE_PROT_RNG_RST 4'h0
`define SNFE_PROT_TB_RST  1'b0
`endif

// ==== core/snfe_sync.v ====
`timescale 1ns/1ps
module snfe_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         reset_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta_q;

  // first stage feeds only the second
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= {W{1'b0}};
      q_o    <= {W{1'b0}};
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

// ==== core/snfe_pause.v ====
`timescale 1ns/1ps
module snfe_pause (
  input  wire clk_i,
  input  wire reset_i,
  input  wire en_i,
  input  wire pause_n_i,
  input  wire sck_i,
  input  wire sck_fall_i,
  output wire hold_o
);
  localparam ST_RUN   = 2'h0;
  localparam ST_ENTER = 2'h1;
  localparam ST_HELD  = 2'h2;
  localparam ST_EXIT  = 2'h3;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg       pn_prev_q;
  wire      pn_fall;
  wire      pn_rise;

  assign pn_fall = pn_prev_q & ~pause_n_i;
  assign pn_rise = ~pn_prev_q & pause_n_i;
  // the falling clock edge that starts a pause is already swallowed
  assign hold_o  = (state_q == ST_HELD) | (state_q == ST_EXIT) |
                   ((state_q == ST_ENTER) & sck_fall_i);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (pn_fall) begin
          state_d = sck_i ? ST_ENTER : ST_HELD;
        end
      end
      ST_ENTER: begin
        if (pn_rise) begin
          state_d = ST_RUN;
        end else if (sck_fall_i) begin
          state_d = ST_HELD;
        end
      end
      ST_HELD: begin
        if (pn_rise) begin
          state_d = sck_i ? ST_EXIT : ST_RUN;
        end
      end
      ST_EXIT: begin
        if (pn_fall) begin
          state_d = ST_HELD;
        end else if (sck_fall_i) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
    // no pause outside selection or when disabled
    if (!en_i) begin
      state_d = ST_RUN;
    end
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q   <= ST_RUN;
      pn_prev_q <= 1'b1;
    end else begin
      state_q   <= state_d;
      pn_prev_q <= pause_n_i;
    end
  end
endmodule

// ==== sim/snfe_host_model.sv ====
`timescale 1ns/1ps
module snfe_host_model (
  input  wire        clk_i,
  input  wire [3:0]  pin_i,
  output logic       cs_n_o,
  output logic       sck_o,
  output logic [3:0] drv_o,
  output logic [3:0] oe_o
);
  logic       cpol;
  logic       wp_n;
  logic       pause_n;
  logic       quad;
  logic [3:0] own;
  logic [3:0] dat;
  // quad phases drop the write protect and pause levels; lines 2 and 3 then carry quad data
  assign oe_o  = quad ? own : own | 4'hc;
  assign drv_o = quad ? dat : {pause_n, wp_n, dat[1:0]};
  initial begin
    cs_n_o  = 1'b1;
    sck_o   = 1'b0;
    cpol    = 1'b0;
    wp_n    = 1'b1;
    pause_n = 1'b1;
    quad    = 1'b0;
    own     = 4'h0;
    dat     = 4'h0;
  end
  // only while deselected, so the idle level never looks like an edge
  task automatic set_mode(input logic m);
    cpol  = m;
    sck_o = m;
  endtask
  task automatic sel();
    @(negedge clk_i);
    cs_n_o = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask
  task automatic desel();
    sck_o = cpol;
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    own    = 4'h0;
    quad   = 1'b0;
    repeat (6) @(negedge clk_i);
  endtask
  // half period of 4 clocks: 160 ns link period
  task automatic xfer(input logic [7:0] tx, input int w, input logic rd, output logic [7:0] rx);
    rx   = 8'h00;
    quad = (w == 4);
    own  = rd ? 4'h0 : (w == 4) ? 4'hf : 4'h1;
    for (int i = 0; i < 8; i += w) begin
      sck_o = 1'b0;
      dat   = 4'(tx >> (8 - w));
      tx    = tx << w;
      repeat (4) @(negedge clk_i);
      rx    = (rx << w) | 8'(w == 1 ? {3'h0, pin_i[1]} : pin_i & 4'((1 << w) - 1));
      sck_o = 1'b1;
      repeat (4) @(negedge clk_i);
    end
  endtask
endmodule

// ==== sim/snfe_front_end_chk.sv ====
`timescale 1ns/1ps
module snfe_front_end_chk (
  input wire        clk_i,
  input wire        reset_i,
  input wire        cs_n_i,
  input wire        sck_i,
  input wire [3:0]  io_i,
  input wire        pause_en_i,
  input wire        lock_write_disable_i,
  input wire        prot_wr_i,
  input wire [3:0]  io_o,
  input wire [3:0]  io_oe_o,
  input wire        selected_o,
  input wire        paused_o,
  input wire        opcode_valid_o,
  input wire [11:0] col_addr_o,
  input wire        col_valid_o,
  input wire        col_err_o,
  input wire        rx_valid_o,
  input wire [3:0]  protect_range_bits_o,
  input wire        protect_top_bottom_o,
  input wire        prot_wr_reject_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  AST_DESEL_FLOAT: assert property (cs_n_i [*6] |-> io_oe_o == 4'h0)
    else $error("output driven while deselected");
  AST_DESEL_DIR: assert property (!selected_o [*3] |-> !io_oe_o[0] && !io_oe_o[2])
    else $error("input-side line driven while deselected");
  AST_PAUSE_FLOAT: assert property (paused_o [*2] |-> io_oe_o == 4'h0)
    else $error("output driven while paused");
  AST_PAUSE_OFF: assert property ((!pause_en_i && !paused_o) [*3] |=> !paused_o)
    else $error("pause entered while disabled");
  AST_PAUSE_SEL: assert property ($rose(paused_o) |-> selected_o)
    else $error("pause entered while deselected");
  AST_PROT_REJ: assert property ((lock_write_disable_i && !io_i[2]) [*6] ##0 prot_wr_i
    |-> ##[1:2] prot_wr_reject_o)
    else $error("locked protect write not refused");
  AST_PROT_KEEP: assert property (prot_wr_reject_o
    |-> $stable(protect_range_bits_o) && $stable(protect_top_bottom_o))
    else $error("protect bits changed on refusal");
  AST_COL_OK: assert property (col_valid_o |-> col_addr_o <= 12'h87f && !col_err_o)
    else $error("column flagged valid out of range");
  AST_COL_BAD: assert property (col_err_o |-> col_addr_o > 12'h87f)
    else $error("column flagged bad in range");
  AST_OUT_FALL: assert property (selected_o && $changed(io_o) && io_oe_o != 4'h0 &&
    $past(io_oe_o) == io_oe_o |-> !$past(sck_i, 3))
    else $error("output bit changed without a clock fall");
  AST_RX_GAP: assert property (rx_valid_o |=> !rx_valid_o [*5])
    else $error("bytes received faster than clock rises");
  AST_OPC_SEL: assert property (opcode_valid_o |-> selected_o)
    else $error("opcode taken while deselected");
  cover property ($rose(paused_o));
  cover property (prot_wr_reject_o);
  cover property (col_err_o && !cs_n_i);
endmodule
bind snfe_front_end snfe_front_end_chk i_chk (.*);

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic        clk_i, reset_i, cs_n_i, sck_i, pause_en_i, lock_write_disable_i, prot_wr_i;
  logic        prot_tb_new_i, selected_o, paused_o, opcode_valid_o, col_valid_o, col_err_o;
  logic        rx_valid_o, tx_req_o, protect_top_bottom_o, prot_wr_reject_o, tog, mdl_tb;
  logic [3:0]  io_i, io_o, io_oe_o, hdrv, hoe, prot_range_new_i, protect_range_bits_o, mdl_rng;
  logic [7:0]  tx_data_i, opcode_o, rx_data_o;
  logic [11:0] col_addr_o;
  int          failures, n_checks, n_txreq;
  logic [7:0]  ops [8] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'h02, 8'h84, 8'h32, 8'h34};
  int          wid [8] = '{1, 1, 2, 4, 1, 1, 4, 4};
  snfe_front_end i_snfe_front_end (.*);
  snfe_host_model i_snfe_host_model (.clk_i(clk_i), .pin_i(io_i), .cs_n_o(cs_n_i),
    .sck_o(sck_i), .drv_o(hdrv), .oe_o(hoe));
  // released lines: pull-ups on 2 and 3, a toggling pattern on 0 and 1
  assign io_i = (io_oe_o & io_o) | (~io_oe_o & hoe & hdrv) | (~io_oe_o & ~hoe & {2'b11, tog, tog});
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) tog <= ~tog;
  always @(posedge clk_i) if (tx_req_o) n_txreq <= n_txreq + 1;
  function automatic logic [3:0] oe_exp(input int w);
    return (w == 1) ? 4'h2 : (w == 2) ? 4'h3 : 4'hf;
  endfunction
  function automatic logic rej_exp(input logic wp_n, input logic lock);
    return !wp_n && lock;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic txn(input logic [7:0] op, input int w, input logic rd, input logic [15:0] a);
    logic [7:0] rx, d;
    int         nq;
    d = 8'($urandom);
    tx_data_i = d;
    i_snfe_host_model.sel();
    check(selected_o, 1'b1);
    i_snfe_host_model.xfer(op, 1, 1'b0, rx);
    check(opcode_o, op);
    i_snfe_host_model.xfer(a[15:8], 1, 1'b0, rx);
    i_snfe_host_model.xfer(a[7:0], 1, 1'b0, rx);
    check(col_addr_o, a[11:0]);
    check(col_err_o, a[11:0] > 12'h87f);
    check(col_valid_o, a[11:0] <= 12'h87f);
    if (rd) i_snfe_host_model.xfer(8'h00, 1, 1'b0, rx);
    nq = n_txreq;
    i_snfe_host_model.xfer(d, w, rd, rx);
    check(16'(n_txreq - nq), {15'h0000, rd});
    check(rd ? rx : rx_data_o, d);
    check(io_oe_o, rd ? oe_exp(w) : 4'h0);
    i_snfe_host_model.desel();
    check(io_oe_o, 4'h0);
    check(selected_o, 1'b0);
  endtask
  initial begin
    logic [15:0] a;
    logic [7:0]  rx;
    logic        rej;
    reset_i = 1'b1;
    pause_en_i = 1'b0;
    lock_write_disable_i = 1'b0;
    prot_wr_i = 1'b0;
    prot_range_new_i = 4'h0;
    prot_tb_new_i = 1'b0;
    tx_data_i = 8'h00;
    tog = 1'b0;
    mdl_rng = 4'h0;
    mdl_tb = 1'b0;
    failures = 0;
    n_checks = 0;
    n_txreq = 0;
    void'($urandom(32'h2df2));
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    check({protect_top_bottom_o, protect_range_bits_o}, 5'h00);
    check(io_oe_o, 4'h0);
    repeat (4) @(negedge clk_i);
    for (int m = 0; m < 2; m++) begin
      i_snfe_host_model.set_mode(m[0]);
      for (int j = 0; j < 8; j++) begin
        a = (j == 0) ? 16'h087f : (j == 1) ? 16'hf880 : 16'($urandom);
        txn(ops[j], wid[j], j < 4, a);
      end
    end
    for (int k = 0; k < 4; k++) begin
      i_snfe_host_model.wp_n = k[0];
      lock_write_disable_i = k[1];
      prot_range_new_i = 4'($urandom);
      prot_tb_new_i = 1'($urandom);
      repeat (8) @(negedge clk_i);
      prot_wr_i = 1'b1;
      @(negedge clk_i);
      prot_wr_i = 1'b0;
      rej = prot_wr_reject_o;
      @(negedge clk_i);
      rej = rej | prot_wr_reject_o;
      if (!rej_exp(k[0], k[1])) begin
        mdl_rng = prot_range_new_i;
        mdl_tb = prot_tb_new_i;
      end
      @(negedge clk_i);
      check(rej, rej_exp(k[0], k[1]));
      check({protect_top_bottom_o, protect_range_bits_o}, {mdl_tb, mdl_rng});
    end
    i_snfe_host_model.set_mode(1'b0);
    i_snfe_host_model.sel();
    i_snfe_host_model.pause_n = 1'b0;
    repeat (8) @(negedge clk_i);
    check(paused_o, 1'b0);
    i_snfe_host_model.pause_n = 1'b1;
    pause_en_i = 1'b1;
    repeat (4) @(negedge clk_i);
    // a pause starts only after a falling edge of its line
    i_snfe_host_model.pause_n = 1'b0;
    repeat (6) @(negedge clk_i);
    check(paused_o, 1'b1);
    i_snfe_host_model.xfer(8'($urandom), 1, 1'b0, rx);
    i_snfe_host_model.pause_n = 1'b1;
    repeat (3) @(negedge clk_i);
    check(paused_o, 1'b1);
    i_snfe_host_model.xfer(8'h0f, 1, 1'b0, rx);
    check(opcode_o, 8'h0f);
    // clock high now: the pause waits for the next clock fall
    i_snfe_host_model.pause_n = 1'b0;
    repeat (6) @(negedge clk_i);
    check(paused_o, 1'b0);
    i_snfe_host_model.xfer(8'($urandom), 1, 1'b0, rx);
    check(paused_o, 1'b1);
    i_snfe_host_model.pause_n = 1'b1;
    repeat (3) @(negedge clk_i);
    i_snfe_host_model.xfer(8'ha5, 1, 1'b0, rx);
    check(rx_data_o, 8'ha5);
    i_snfe_host_model.desel();
    pause_en_i = 1'b0;
    test_done();
  end
  // whole run is near 4800 clocks; this leaves a wide margin
  initial begin
    #500000;
    failures++;
    test_done();
  end
endmodule
